// ===== core/aogt_trim_map.vh
// Register indexes, field layout and reset values of the trim register bank
`ifndef AOGT_TRIM_MAP_VH
`define AOGT_TRIM_MAP_VH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define AOGT_IDX_B_IN1_OFS 10'h34C
`define AOGT_IDX_B_IN2_OFS 10'h34E
`define AOGT_IDX_DUAL_A0 10'h350
`define AOGT_IDX_DUAL_A1 10'h351
`define AOGT_IDX_DUAL_B0 10'h352
`define AOGT_IDX_DUAL_B1 10'h353
`define AOGT_IDX_SINGLE_A0 10'h354
`define AOGT_IDX_SINGLE_A1 10'h355
`define AOGT_IDX_SINGLE_B0 10'h356
`define AOGT_IDX_SINGLE_B1 10'h357

// ==========================================================================
// Bus geometry
`define AOGT_ADDR_W 12
`define AOGT_ENTRIES 10
`define AOGT_SEL_W 4

// ==========================================================================
// Field layout
`define AOGT_OFS_MSB 11
`define AOGT_OFS_W 12
`define AOGT_OFS_RSV_MSB 15
`define AOGT_OFS_RSV_LSB 12
`define AOGT_GAIN_MSB 4
`define AOGT_GAIN_W 5
`define AOGT_GAIN_RSV_MSB 7
`define AOGT_GAIN_RSV_LSB 5
`define AOGT_OFS_REG_W 16
`define AOGT_GAIN_REG_W 8

// ==========================================================================
// Reserved field reset value and bus responses
`define AOGT_RSV_OFS_RST 4'h0
`define AOGT_RSV_GAIN_RST 3'h0
`define AOGT_RESP_OKAY 2'h0
`define AOGT_RESP_SLVERR 2'h2

`endif

// ===== core/aogt_trim_regs.v
// Offset and fine-gain trim register bank with AXI4-Lite slave
`timescale 1ns/1ps
`include "aogt_trim_map.vh"
// Contract
// - Core B input-one 12-bit offset word drives core B under foreground calibration.
// - Separate 12-bit core B input-two offset word at 0x34E, both channel modes.
// - Dual-mode gain words at 0x350..0x353: A0, A1, B0, B1.
// - Independent single-mode gain words at 0x354..0x357, same order.
// - Gain registers: 5-bit field bits 4:0, bits 7:5 reserved storage reset zero.
// - At reset every trim word loads from factory fuse storage.
// - Offset registers 16 bits: value 11:0, bits 15:12 reserved storage reset zero.
module aogt_trim_regs (
	input wire clk,
	input wire reset_n,
	// AXI4-Lite slave
	input wire [`AOGT_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`AOGT_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Factory fuse defaults, stable while reset_n is low
	input wire [11:0] fuseCoreBInput1Offset,
	input wire [11:0] fuseCoreBInput2Offset,
	input wire [39:0] fuseFineGain,
	// Operating mode from the rest of the converter
	input wire fgCalEnable,
	input wire singleChannelMode,
	// Trims toward the converter datapath
	output reg [11:0] coreBInput1Offset,
	output reg [11:0] coreBInput2Offset,
	output reg [4:0] coreAGainBank0,
	output reg [4:0] coreAGainBank1,
	output reg [4:0] coreBGainBank0,
	output reg [4:0] coreBGainBank1
);

	// ======================================================================
	// Storage: entry 0/1 offsets, 2..5 dual gains, 6..9 single gains
	reg [15:0] trimMem_r [0:`AOGT_ENTRIES-1];

	// ======================================================================
	// Address decode
	function [`AOGT_SEL_W:0] decodeIdx;
		input [`AOGT_ADDR_W-1:0] addr;
		begin
			case (addr[`AOGT_ADDR_W-1:2])
				`AOGT_IDX_B_IN1_OFS: decodeIdx = {1'b1, 4'h0};
				`AOGT_IDX_B_IN2_OFS: decodeIdx = {1'b1, 4'h1};
				`AOGT_IDX_DUAL_A0: decodeIdx = {1'b1, 4'h2};
				`AOGT_IDX_DUAL_A1: decodeIdx = {1'b1, 4'h3};
				`AOGT_IDX_DUAL_B0: decodeIdx = {1'b1, 4'h4};
				`AOGT_IDX_DUAL_B1: decodeIdx = {1'b1, 4'h5};
				`AOGT_IDX_SINGLE_A0: decodeIdx = {1'b1, 4'h6};
				`AOGT_IDX_SINGLE_A1: decodeIdx = {1'b1, 4'h7};
				`AOGT_IDX_SINGLE_B0: decodeIdx = {1'b1, 4'h8};
				`AOGT_IDX_SINGLE_B1: decodeIdx = {1'b1, 4'h9};
				default: decodeIdx = {1'b0, 4'h0};
			endcase
		end
	endfunction

	// ======================================================================
	// Write channel capture; address and data may arrive in either order
	reg awHeld_r;
	reg wHeld_r;
	reg [`AOGT_ADDR_W-1:0] awAddr_r;
	reg [15:0] wData_r;
	reg [1:0] wStrb_r;
	wire [`AOGT_SEL_W:0] wrDec;
	wire wrFire;

	assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
	assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
	assign wrDec = decodeIdx(awAddr_r);
	assign wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;

	always @(posedge clk) begin
		if (!reset_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= {`AOGT_ADDR_W{1'b0}};
			wData_r <= 16'h0000;
			wStrb_r <= 2'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AOGT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata[15:0];
				wStrb_r <= s_axi_wstrb[1:0];
			end
			if (wrFire) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrDec[`AOGT_SEL_W] ? `AOGT_RESP_OKAY : `AOGT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Register entries; fuse values are loaded by the synchronous reset
	genvar gi;
	generate
		for (gi = 0; gi < `AOGT_ENTRIES; gi = gi + 1) begin : gEntry
			localparam [3:0] IDX = gi;
			wire hit;
			wire [15:0] fuseWord;
			assign hit = wrFire & wrDec[`AOGT_SEL_W] & (wrDec[`AOGT_SEL_W-1:0] == IDX);
			// Fuse slice chosen at elaboration so no branch indexes out of range
			if (gi == 0) begin : gOfs0
				assign fuseWord = {`AOGT_RSV_OFS_RST, fuseCoreBInput1Offset};
			end else if (gi == 1) begin : gOfs1
				assign fuseWord = {`AOGT_RSV_OFS_RST, fuseCoreBInput2Offset};
			end else begin : gGain
				assign fuseWord = {8'h00, `AOGT_RSV_GAIN_RST,
					fuseFineGain[(gi-2)*5 +: 5]};
			end
			always @(posedge clk) begin
				if (!reset_n) begin
					trimMem_r[gi] <= fuseWord;
				end else if (hit) begin
					if (wStrb_r[0]) begin
						trimMem_r[gi][7:0] <= wData_r[7:0];
					end
					// Gain registers are only eight bits wide; upper lane ignored
					if (wStrb_r[1] && (gi < 2)) begin
						trimMem_r[gi][15:8] <= wData_r[15:8];
					end
				end
			end
		end
	endgenerate

	// ======================================================================
	// Read channel; one cycle from address taken to data valid
	wire [`AOGT_SEL_W:0] rdDec;

	assign s_axi_arready = ~s_axi_rvalid;
	assign rdDec = decodeIdx(s_axi_araddr);

	always @(posedge clk) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AOGT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (rdDec[`AOGT_SEL_W]) begin
				s_axi_rdata <= {16'h0000, trimMem_r[rdDec[`AOGT_SEL_W-1:0]]};
				s_axi_rresp <= `AOGT_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `AOGT_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// Datapath trims, registered so a mode flip never glitches the core
	wire [3:0] gainBase;

	assign gainBase = singleChannelMode ? 4'h6 : 4'h2;

	always @(posedge clk) begin
		if (!reset_n) begin
			coreBInput1Offset <= 12'h000;
			coreBInput2Offset <= 12'h000;
			coreAGainBank0 <= 5'h00;
			coreAGainBank1 <= 5'h00;
			coreBGainBank0 <= 5'h00;
			coreBGainBank1 <= 5'h00;
		end else begin
			// Zero offset while calibration is off leaves the core untouched
			coreBInput1Offset <= fgCalEnable ? trimMem_r[0][11:0] : 12'h000;
			coreBInput2Offset <= fgCalEnable ? trimMem_r[1][11:0] : 12'h000;
			coreAGainBank0 <= trimMem_r[gainBase][4:0];
			coreAGainBank1 <= trimMem_r[gainBase + 4'h1][4:0];
			coreBGainBank0 <= trimMem_r[gainBase + 4'h2][4:0];
			coreBGainBank1 <= trimMem_r[gainBase + 4'h3][4:0];
		end
	end

endmodule

// ===== tb/aogt_trim_monitor.sv
// Bus and datapath checks for the trim register bank
`timescale 1ns/1ps
module aogt_trim_monitor (
	input wire clk,
	input wire reset_n,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire fgCalEnable,
	input wire [11:0] coreBInput1Offset,
	input wire [11:0] coreBInput2Offset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Both halves taken together: held at that edge, fired at the next, bvalid seen after
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write not answered");
	a_bvalid_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rvalid_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_offset_inert: assert property (!fgCalEnable |=> coreBInput1Offset == 12'h000
		&& coreBInput2Offset == 12'h000) else $error("offset applied without calibration");
endmodule
bind aogt_trim_regs aogt_trim_monitor u_mon (.clk(clk), .reset_n(reset_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fgCalEnable(fgCalEnable),
	.coreBInput1Offset(coreBInput1Offset), .coreBInput2Offset(coreBInput2Offset));

// ===== tb/tb_adc_offset_gain_trim_regs.sv
// Self-checking bench for the trim register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", n, e, a); end end
module tb_adc_offset_gain_trim_regs;
	reg clk = 0, reset_n = 0, awValid = 0, wValid = 0, arValid = 0, fgCal = 0, single = 0;
	reg [11:0] awAddr = 12'h000, arAddr = 12'h000, fuse1 = 12'h000, fuse2 = 12'h000;
	reg [31:0] wData = 32'h00000000;
	reg [39:0] fuseG = 40'h0000000000;
	reg [15:0] expv [0:9];
	wire awReady, wReady, bValid, arReady, rValid;
	wire [1:0] bResp, rResp;
	wire [31:0] rData;
	wire [11:0] ofs1, ofs2;
	wire [4:0] gA0, gA1, gB0, gB1;
	int miscompares = 0, samplesChecked = 0, cycles = 0;
	// Responses always accepted at once; stalls on b and r are not exercised
	aogt_trim_regs u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(1'b1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
		.fuseCoreBInput1Offset(fuse1), .fuseCoreBInput2Offset(fuse2), .fuseFineGain(fuseG),
		.fgCalEnable(fgCal), .singleChannelMode(single), .coreBInput1Offset(ofs1),
		.coreBInput2Offset(ofs2), .coreAGainBank0(gA0), .coreAGainBank1(gA1),
		.coreBGainBank0(gB0), .coreBGainBank1(gB1));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stopTest;
		end
	end
	// ==========================================================================
	// Bus tasks
	function [11:0] adr(int k);
		return (k < 2 ? 12'h34C + 2 * k : 12'h34E + k) * 4;
	endfunction
	task automatic wr(input [11:0] a, input [15:0] d, output [1:0] r);
		awAddr <= a;
		wData <= ($urandom << 16) | d;
		awValid <= 1;
		wValid <= 1;
		forever begin
			@(posedge clk);
			if (awReady) awValid <= 0;
			if (wReady) wValid <= 0;
			if (bValid) begin
				r = bResp;
				break;
			end
		end
	endtask
	task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
		arAddr <= a;
		arValid <= 1;
		forever begin
			@(posedge clk);
			if (arReady) arValid <= 0;
			if (rValid) begin
				d = rData;
				r = rResp;
				break;
			end
		end
	endtask
	task automatic chkAll;
		reg [31:0] d;
		reg [1:0] r;
		for (int k = 0; k < 10; k++) begin
			rd(adr(k), d, r);
			`CHK("readback", {16'h0000, expv[k]}, d)
		end
		for (int m = 0; m < 4; m++) begin
			fgCal <= m[0];
			single <= m[1];
			repeat (2) @(posedge clk);
			`CHK("gains", {expv[2 + 4 * m[1]][4:0], expv[3 + 4 * m[1]][4:0], expv[4 + 4 * m[1]][4:0],
				expv[5 + 4 * m[1]][4:0]}, {gA0, gA1, gB0, gB1})
			`CHK("offsets", m[0] ? {expv[0][11:0], expv[1][11:0]} : 24'h000000, {ofs1, ofs2})
		end
	endtask
	task stopTest;
		if (miscompares == 0 && samplesChecked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========================================================================
	// Main sequence
	initial begin
		reg [31:0] d;
		reg [1:0] r;
		void'($urandom(2));
		fuse1 = $urandom;
		fuse2 = $urandom;
		fuseG = {$urandom, $urandom};
		expv[0] = fuse1;
		expv[1] = fuse2;
		for (int k = 0; k < 8; k++) expv[2 + k] = {11'h000, fuseG[5 * k +: 5]};
		repeat (4) @(posedge clk);
		reset_n <= 1;
		chkAll;
		for (int k = 0; k < 10; k++) begin
			d = (k % 3 == 0) ? 32'h0000FFFF : $urandom;
			wr(adr(k), d[15:0], r);
			`CHK("bresp", 2'h0, r)
			expv[k] = k < 2 ? d[15:0] : {8'h00, d[7:0]};
		end
		wr(12'hD34, 16'hFFFF, r);
		`CHK("unmapped bresp", 2'h2, r)
		rd(12'hD34, d, r);
		`CHK("unmapped read", {2'h2, 32'h0}, {r, d})
		chkAll;
		stopTest;
	end
endmodule
